// file: hw/int_sched.sv
// Operation
// [R1] Poll descriptor every 2^(b-1) microframes, b from one to nine; for b six to nine the code polls every 2^(b-2) microframes.
// [R2] For b up to four period bits are zero; mask alone selects microframes.
// [R3] Split bit one gives split transaction, zero gives high-speed transaction.
// [R4] Token 00 sends OUT, 01 sends IN; endpoint kind must read 11.
// [R5] Target device address comes from descriptor bits 41 to 35.
// [R6] Endpoint number is bits 34..32 on top of bit 31.
// [R7] Up to multiplier packets per execution; multiplier 00 is undefined.
// [R8] Each packet carries at most the eleven-bit maximum payload bytes.
// [R9] Fifteen-bit transfer count is the descriptor total, up to 32 kB minus one.
// [R10] Software sets valid; hardware clears it when done or on fatal error.
// [R11] Software programs mask pattern matching the chosen microframe rate.
// [R12] Slow rates use one mask bit and a period under the leading-one range.
module int_sched
  import int_sched_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Descriptor write port from the processor side
  input  wire logic                  desc_wr_en,
  input  wire logic                  desc_wr_sel,
  input  wire logic [DESC_W-1:0]     desc_wr_data,
  // Bus timing from the frame counter
  input  wire logic                  sof_pulse,
  input  wire logic [FRAME_W-1:0]    frame_number,
  input  wire logic [2:0]            microframe,
  // Transaction engine handshake
  output logic                       txn_start,
  input  wire logic                  txn_done,
  input  wire logic [10:0]           txn_bytes,
  input  wire logic                  txn_fatal,
  input  wire logic                  txn_short,
  // Transaction parameters
  output logic                       txn_split,
  output logic                       txn_in,
  output logic [DEV_ADDR_W-1:0]      txn_dev_addr,
  output logic [3:0]                 txn_endpoint,
  output logic [MAX_PAY_W-1:0]       txn_len,
  // Status
  output logic                       desc_valid,
  output logic                       desc_halted,
  output logic                       desc_error,
  output logic [XFER_CNT_W-1:0]      bytes_done,
  output logic [3:0]                 rate_index
);

  typedef enum logic [1:0] {IDLE, ISSUE, WAIT_DONE} state_e;

  state_e                  state;
  state_e                  next_state;
  logic [DESC_W-1:0]       low_word;
  logic [DESC_W-1:0]       high_word;
  logic                    clear_valid;
  logic                    upd_high;
  logic [DESC_W-1:0]       next_high;
  logic [1:0]              pkt_left;
  logic [XFER_CNT_W-1:0]   remaining;
  logic [XFER_CNT_W-1:0]   next_done;
  logic [PERIOD_W-1:0]     period;
  logic [7:0]              sel_mask;
  logic [1:0]              kind;
  logic [1:0]              mult;
  logic [1:0]              token;
  logic [XFER_CNT_W-1:0]   xfer_total;
  logic                    frame_hit;
  logic                    due;
  logic                    cfg_ok;
  logic                    finish;
  token_e                  token_kind;
  logic [XFER_CNT_W-1:0]   left_now;
  logic [7:0]              slot_sel;
  logic                    slot_hit;

  desc_store u_store (
    .core_clk       (core_clk),
    .rstn           (rstn),
    .wr_en          (desc_wr_en),
    .wr_sel         (desc_wr_sel),
    .wr_data        (desc_wr_data),
    .hw_clear_valid (clear_valid),
    .hw_upd_high    (upd_high),
    .hw_high_data   (next_high),
    .low_word       (low_word),
    .high_word      (high_word)
  );

  assign period     = high_word[PERIOD_LSB +: PERIOD_W];
  assign sel_mask   = high_word[SEL_MASK_LSB +: 8];
  assign kind       = low_word[KIND_LSB +: 2];
  assign mult       = low_word[MULT_LSB +: 2];
  assign token      = low_word[TOKEN_LSB +: 2];
  assign xfer_total = low_word[XFER_CNT_LSB +: XFER_CNT_W];                // [R9]
  assign bytes_done = high_word[DONE_CNT_LSB +: XFER_CNT_W];
  assign desc_valid = low_word[VALID_BIT];
  assign desc_halted = high_word[HALT_BIT];

  rate_decode u_rate (
    .period     (period),
    .sel_mask   (sel_mask),
    .rate_index (rate_index)
  );

  always_comb
  begin
    case (token)
      TOKEN_OUT: token_kind = TOKEN_KIND_OUT;
      TOKEN_IN:  token_kind = TOKEN_KIND_IN;
      default:   token_kind = TOKEN_KIND_BAD;
    endcase
  end

  // Period matches when the frame's low bits under the leading one equal the period's
  always_comb
  begin
    frame_hit = 1'b0;
    case (rate_index)
      4'h1, 4'h2, 4'h3, 4'h4: frame_hit = 1'b1;                            // [R2]
      4'h5: frame_hit = 1'b1;                                              // [R1]
      4'h6: frame_hit = frame_number[0] == period[0];                      // [R1]
      4'h7: frame_hit = frame_number[1:0] == period[1:0];                  // [R1]
      4'h8: frame_hit = frame_number[2:0] == period[2:0];                  // [R1]
      4'h9: frame_hit = frame_number[3:0] == period[3:0];                  // [R12]
      default: frame_hit = 1'b0;
    endcase
  end

  // One compare per microframe slot keeps the mask test a flat OR
  for (genvar g = 0; g < 8; g++)
  begin : g_slot
    assign slot_sel[g] = sel_mask[g] && microframe == 3'(g);                       // [R2]
  end

  assign slot_hit = |slot_sel;

  // Odd frames for 2 ms: period 0 0001 places the poll on odd frame numbers
  assign due = sof_pulse && desc_valid && !desc_halted && slot_hit                 // [R2]
             && (rate_index == 4'h5 ? frame_number[0] : frame_hit);               // [R1]

  // Malformed kind, token or multiplier is dropped as fatal rather than guessed at; a rate that decodes to none is never polled
  assign cfg_ok = kind == KIND_INTR && mult != MULT_UNDEF                   // [R4] [R7]
                && token_kind != TOKEN_KIND_BAD && rate_index != RATE_NONE; // [R12]

  assign remaining = xfer_total - bytes_done;
  assign txn_start = state == ISSUE;

  // Look past the packet just finished so a follow-on packet never overruns the total
  assign left_now  = (state == WAIT_DONE) ? xfer_total - next_done : remaining;

  // Never hand the engine more than one packet's worth or more than is left
  function automatic logic [MAX_PAY_W-1:0] clamp_len(input logic [XFER_CNT_W-1:0] left,
                                                    input logic [MAX_PAY_W-1:0]  max_pay);
    return (left < {4'h0, max_pay}) ? left[MAX_PAY_W-1:0] : max_pay;
  endfunction

  always_comb
  begin
    next_state = state;
    case (state)
      IDLE:      next_state = (due && cfg_ok && remaining != '0) ? ISSUE : IDLE;
      ISSUE:     next_state = WAIT_DONE;
      WAIT_DONE:
        if (txn_done)
          next_state = (txn_fatal || finish || pkt_left == 2'h1) ? IDLE : ISSUE;  // [R7]
      default:   next_state = IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state <= IDLE;
    else
      state <= next_state;
  end

  // Packet budget per execution
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      pkt_left <= 2'h0;
    else if (state == IDLE)
      pkt_left <= mult;                                                    // [R7]
    else if (state == WAIT_DONE && txn_done)
      pkt_left <= pkt_left - 2'h1;
  end

  // Latched transaction parameters
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      txn_split    <= 1'b0;
      txn_in       <= 1'b0;
      txn_dev_addr <= '0;
      txn_endpoint <= 4'h0;
      txn_len      <= '0;
    end
    else if (next_state == ISSUE)
    begin
      txn_split    <= low_word[SPLIT_BIT];                                 // [R3]
      txn_in       <= token_kind == TOKEN_KIND_IN;                         // [R4]
      txn_dev_addr <= low_word[DEV_ADDR_LSB +: DEV_ADDR_W];                // [R5]
      txn_endpoint <= {low_word[EP_UPPER_LSB +: 3], low_word[EP_LSB_BIT]}; // [R6]
      txn_len      <= clamp_len(left_now, low_word[MAX_PAY_LSB +: MAX_PAY_W]);   // [R8]
    end
  end

  assign next_done = bytes_done + {4'h0, txn_bytes};
  assign finish    = next_done >= xfer_total || txn_short;

  // Status write-back: byte count, halt on fatal, active mirrors valid
  always_comb
  begin
    next_high   = high_word;
    upd_high    = 1'b0;
    clear_valid = 1'b0;
    if (state == IDLE && due && !cfg_ok)
    begin
      upd_high              = 1'b1;
      clear_valid           = 1'b1;                                        // [R10]
      next_high[HALT_BIT]   = 1'b1;
      next_high[ACTIVE_BIT] = 1'b0;
    end
    else if (state == WAIT_DONE && txn_done)
    begin
      upd_high = 1'b1;
      next_high[DONE_CNT_LSB +: XFER_CNT_W] = next_done;                   // [R9]
      if (txn_fatal)
      begin
        next_high[HALT_BIT] = 1'b1;
        clear_valid         = 1'b1;                                        // [R10]
      end
      else if (finish)
        clear_valid = 1'b1;                                                // [R10]
      next_high[ACTIVE_BIT] = !clear_valid;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      desc_error <= 1'b0;
    // A halt that really lands wins over the clear of a same-cycle write
    else if (upd_high && next_high[HALT_BIT] && !(desc_wr_en && desc_wr_sel))
      desc_error <= 1'b1;                                                  // [R10]
    else if (desc_wr_en)
      desc_error <= 1'b0;
  end

endmodule

// file: include/int_sched_pkg.sv
package int_sched_pkg;

  // Descriptor geometry: one 64-bit word for DW1:DW0, one for DW3:DW2
  localparam int DESC_W = 64;

  // Low word (DW1:DW0) field positions
  localparam int SPLIT_BIT      = 46;
  localparam int KIND_LSB       = 44;
  localparam int TOKEN_LSB      = 42;
  localparam int DEV_ADDR_LSB   = 35;
  localparam int EP_UPPER_LSB   = 32;
  localparam int EP_LSB_BIT     = 31;
  localparam int MULT_LSB       = 29;
  localparam int MAX_PAY_LSB    = 18;
  localparam int XFER_CNT_LSB   = 3;
  localparam int VALID_BIT      = 0;

  // High word (DW3:DW2) field positions
  localparam int ACTIVE_BIT     = 63;
  localparam int HALT_BIT       = 62;
  localparam int DONE_CNT_LSB   = 32;
  localparam int PERIOD_LSB     = 3;
  // Mask sits in the spare top byte of DW2 so it never aliases the period bits
  localparam int SEL_MASK_LSB   = 24;

  // Field widths
  localparam int DEV_ADDR_W     = 7;
  localparam int MAX_PAY_W      = 11;
  localparam int XFER_CNT_W     = 15;
  localparam int PERIOD_W       = 5;
  localparam int FRAME_W        = 11;

  // Codings
  localparam logic [1:0] TOKEN_OUT   = 2'h0;
  localparam logic [1:0] TOKEN_IN    = 2'h1;
  localparam logic [1:0] KIND_INTR   = 2'h3;
  localparam logic [1:0] MULT_UNDEF  = 2'h0;

  // Reset values
  localparam logic [DESC_W-1:0] DESC_RESET = 64'h0;
  localparam logic [3:0]        RATE_NONE  = 4'h0;

  typedef enum logic [1:0] {TOKEN_KIND_OUT, TOKEN_KIND_IN, TOKEN_KIND_BAD} token_e;

endpackage

// file: hw/desc_store.sv
module desc_store
  import int_sched_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Software write port
  input  wire logic              wr_en,
  input  wire logic              wr_sel,
  input  wire logic [DESC_W-1:0] wr_data,
  // Hardware update of the valid bit and the high word
  input  wire logic              hw_clear_valid,
  input  wire logic              hw_upd_high,
  input  wire logic [DESC_W-1:0] hw_high_data,
  // Registered contents
  output logic      [DESC_W-1:0] low_word,
  output logic      [DESC_W-1:0] high_word
);

  // Low word: software write, hardware may only drop the valid bit
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      low_word <= DESC_RESET;
    else if (wr_en && !wr_sel)
      low_word <= wr_data;
    else if (hw_clear_valid)
      low_word[VALID_BIT] <= 1'b0;
  end

  // High word: a software write wins over a status update in the same cycle
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      high_word <= DESC_RESET;
    else if (wr_en && wr_sel)
      high_word <= wr_data;
    else if (hw_upd_high)
      high_word <= hw_high_data;
  end

endmodule

// file: hw/rate_decode.sv
module rate_decode
  import int_sched_pkg::*;
(
  // Descriptor scheduling fields
  input  wire logic [PERIOD_W-1:0] period,
  input  wire logic [7:0]          sel_mask,
  // Decoded rate index b (1 to 9), zero when the fields are inconsistent
  output logic      [3:0]          rate_index
);

  function automatic logic [3:0] ones(input logic [7:0] m);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
      n = n + {3'h0, m[i]};
    return n;
  endfunction

  always_comb
  begin
    rate_index = RATE_NONE;
    if (period == '0)
    begin
      case (ones(sel_mask))
        4'h8: rate_index = 4'h1;
        4'h4: rate_index = (sel_mask == 8'hAA || sel_mask == 8'h55) ? 4'h2 : RATE_NONE;
        4'h2: rate_index = 4'h3;
        4'h1: rate_index = 4'h4;
        default: rate_index = RATE_NONE;
      endcase
    end
    else if (ones(sel_mask) == 4'h1)
    begin
      // Leading one of the period selects rate index 5 to 9
      if (period[4])      rate_index = 4'h9;
      else if (period[3]) rate_index = 4'h8;
      else if (period[2]) rate_index = 4'h7;
      else if (period[1]) rate_index = 4'h6;
      else                rate_index = 4'h5;
    end
  end

endmodule

// file: bench/int_sched_checker.sv
module int_sched_checker
  import int_sched_pkg::*;
(
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  rstn,
  // Inputs
  input wire logic                  desc_wr_en,
  input wire logic                  sof_pulse,
  input wire logic                  txn_done,
  input wire logic [10:0]           txn_bytes,
  input wire logic                  txn_fatal,
  // Outputs
  input wire logic                  txn_start,
  input wire logic [DEV_ADDR_W-1:0] txn_dev_addr,
  input wire logic [MAX_PAY_W-1:0]  txn_len,
  input wire logic                  desc_valid,
  input wire logic                  desc_halted,
  input wire logic [XFER_CNT_W-1:0] bytes_done,
  input wire logic [3:0]            rate_index
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  a_start_needs_valid:
    assert property (txn_start |-> desc_valid && !desc_halted) else $error("Start without live descriptor");
  a_start_has_cause:
    assert property (txn_start |-> $past(sof_pulse) || $past(txn_done)) else $error("Start without poll");
  a_start_one_cycle:
    assert property (txn_start |=> !txn_start) else $error("Start longer than one cycle");
  a_rate_in_range:
    assert property (rate_index <= 4'h9 && !(txn_start && rate_index == 4'h0)) else $error("Rate index bad");
  a_fields_hold:
    assert property (!txn_start |-> $stable(txn_dev_addr) && $stable(txn_len)) else $error("Fields moved");
  a_bytes_add:
    assert property (txn_done && !txn_fatal && !desc_wr_en |=>
      bytes_done == $past(bytes_done) + 15'($past(txn_bytes))) else $error("Byte count wrong");
  a_fatal_clears:
    assert property (txn_done && txn_fatal && !desc_wr_en |=> !desc_valid && !txn_start) else $error("Fatal kept");
  a_halt_quiet:
    assert property (desc_halted |-> !txn_start) else $error("Start while halted");
endmodule

// file: bench/txn_engine_model.sv
module txn_engine_model
  import int_sched_pkg::*;
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Requests and commanded faults
  input  wire logic                 txn_start,
  input  wire logic [MAX_PAY_W-1:0] txn_len,
  input  wire logic [3:0]           lag,
  input  wire logic                 fail,
  input  wire logic                 cut,
  // Answers
  output logic                      txn_done,
  output logic [10:0]               txn_bytes,
  output logic                      txn_fatal,
  output logic                      txn_short
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {txn_done, txn_fatal, txn_short, txn_bytes} = '0;
    forever
    begin
      @(posedge core_clk);
      if (txn_start && rstn)
      begin
        repeat (lag) @(posedge core_clk);
        txn_done <= 1'b1;
        txn_bytes <= cut ? txn_len >> 1 : txn_len;
        txn_fatal <= fail;
        txn_short <= cut;
        @(posedge core_clk);
      end
      // Stale count inverted so an idle bus never looks like an answer
      {txn_done, txn_fatal, txn_short} <= 3'h0;
      txn_bytes <= ~txn_bytes;
    end
  end
endmodule

// file: bench/hs_interrupt_descriptor_sched_test.sv
module hs_interrupt_descriptor_sched_test
  import int_sched_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rstn, desc_wr_en, desc_wr_sel, sof_pulse, fail, cut;
  logic [63:0] desc_wr_data;
  logic [10:0] frame_number, txn_bytes, txn_len;
  logic [2:0]  microframe;
  logic [3:0]  lag, txn_endpoint, rate_index;
  logic        txn_start, txn_done, txn_fatal, txn_short, txn_split, txn_in;
  logic        desc_valid, desc_halted, desc_error;
  logic [6:0]  txn_dev_addr;
  logic [14:0] bytes_done;
  logic [23:0] notes[$];
  int          failures = 0;
  int          compares = 0;
  int_sched int_sched_i (.core_clk(core_clk), .rstn(rstn), .desc_wr_en(desc_wr_en), .desc_wr_sel(desc_wr_sel),
    .desc_wr_data(desc_wr_data), .sof_pulse(sof_pulse), .frame_number(frame_number), .microframe(microframe),
    .txn_start(txn_start), .txn_done(txn_done), .txn_bytes(txn_bytes), .txn_fatal(txn_fatal),
    .txn_short(txn_short), .txn_split(txn_split), .txn_in(txn_in), .txn_dev_addr(txn_dev_addr),
    .txn_endpoint(txn_endpoint), .txn_len(txn_len), .desc_valid(desc_valid), .desc_halted(desc_halted),
    .desc_error(desc_error), .bytes_done(bytes_done), .rate_index(rate_index));
  txn_engine_model txn_engine_model_i (.core_clk(core_clk), .rstn(rstn), .txn_start(txn_start),
    .txn_len(txn_len), .lag(lag), .fail(fail), .cut(cut), .txn_done(txn_done), .txn_bytes(txn_bytes),
    .txn_fatal(txn_fatal), .txn_short(txn_short));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      failures++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic final_report;
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(negedge core_clk)
    if (rstn && txn_start === 1'b1)
    begin
      if (notes.size() == 0)
        check(32'h1, 32'h0);
      else
        check({txn_split, txn_in, txn_dev_addr, txn_endpoint, txn_len}, notes.pop_front());
    end
  task automatic put(input logic sel, input logic [63:0] d);
    @(negedge core_clk);
    {desc_wr_en, desc_wr_sel, desc_wr_data} = {1'b1, sel, d};
    @(negedge core_clk);
    desc_wr_en = 1'b0;
  endtask
  task automatic sof(input logic [10:0] f, input logic [2:0] m);
    @(negedge core_clk);
    {sof_pulse, frame_number, microframe} = {1'b1, f, m};
    @(negedge core_clk);
    sof_pulse = 1'b0;
  endtask
  task automatic run(input logic [1:0] tok, kd, mult, input logic sp, input logic [1:0] rt, input int npk);
    logic [6:0]  a;
    logic [3:0]  ep;
    logic [10:0] len;
    logic        ok;
    int          n;
    logic [7:0]  mk;
    logic [4:0]  pr;
    logic [10:0] f0, f1;
    logic [2:0]  m0, m1;
    logic [3:0]  rx;
    // Per rate code: mask, period, off-slot and on-slot frame and microframe, expected rate
    case (rt)
      2'h0: {mk, pr, f0, m0, f1, m1, rx} = {8'h01, 5'h00, 11'h004, 3'h1, 11'h004, 3'h0, 4'h4};
      2'h1: {mk, pr, f0, m0, f1, m1, rx} = {8'h08, 5'h01, 11'h002, 3'h3, 11'h003, 3'h3, 4'h5};
      2'h2: {mk, pr, f0, m0, f1, m1, rx} = {8'hAA, 5'h00, 11'h004, 3'h0, 11'h004, 3'h1, 4'h2};
      default: {mk, pr, f0, m0, f1, m1, rx} = {8'h80, 5'h10, 11'h001, 3'h7, 11'h010, 3'h7, 4'h9};
    endcase
    a = 7'($urandom);
    ep = 4'($urandom);
    len = 11'($urandom_range(1, 2000));
    lag = 4'($urandom_range(0, 5));
    ok = kd == KIND_INTR && mult != MULT_UNDEF && !tok[1];
    put(1'b1, {32'h0, mk, 16'h0, pr, 3'h0});
    put(1'b0, {17'h0, sp, kd, tok, a, ep, mult, len, 15'(len * npk), 3'h1});
    // Off-slot poll first; notes go in after it, so a wrong start finds none
    sof(f0, m0);
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < (!ok ? 0 : (fail || cut) ? 1 : npk); i++)
      notes.push_back({sp, tok == TOKEN_IN, a, ep, len});
    sof(f1, m1);
    for (n = 0; desc_valid !== 1'b0 && n < 300; n++)
      @(negedge core_clk);
    check(n < 300, 1);
    if (n == 300)
      final_report;
    else
    begin
      check(notes.size(), 0);
      check(rate_index, rx);
      check(desc_error, fail || !ok);
      check(desc_halted, fail || !ok);
      if (ok && !fail)
        check(bytes_done, cut ? 15'(len >> 1) : 15'(len * npk));
      $display("Test done: token %0h kind %0h mult %0h split %0h rate %0h", tok, kd, mult, sp, rx);
    end
  endtask
  initial
  begin
    {rstn, desc_wr_en, desc_wr_sel, sof_pulse, fail, cut} = '0;
    {desc_wr_data, frame_number, microframe, lag} = '0;
    void'($urandom(32'h991C5998));
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    for (int t = 0; t < 4; t++)
      run({1'b0, t[0]}, KIND_INTR, 2'h1, t[1], 2'(t), 1);
    run(TOKEN_IN, KIND_INTR, 2'h3, 1'b0, 2'h0, 3);
    fail = 1'b1;
    run(TOKEN_OUT, KIND_INTR, 2'h2, 1'b1, 2'h0, 2);
    fail = 1'b0;
    cut = 1'b1;
    run(TOKEN_IN, KIND_INTR, 2'h1, 1'b0, 2'h1, 1);
    cut = 1'b0;
    run(TOKEN_IN, KIND_INTR, MULT_UNDEF, 1'b0, 2'h0, 1);
    run(2'h2, KIND_INTR, 2'h1, 1'b0, 2'h0, 1);
    run(TOKEN_OUT, 2'h2, 2'h1, 1'b0, 2'h0, 1);
    final_report;
  end
endmodule
bind int_sched int_sched_checker int_sched_checker_i (.core_clk(core_clk), .rstn(rstn), .desc_wr_en(desc_wr_en),
  .sof_pulse(sof_pulse), .txn_done(txn_done), .txn_bytes(txn_bytes), .txn_fatal(txn_fatal), .txn_start(txn_start),
  .txn_dev_addr(txn_dev_addr), .txn_len(txn_len), .desc_valid(desc_valid), .desc_halted(desc_halted),
  .bytes_done(bytes_done), .rate_index(rate_index));
